// file: verilog/pst_power_switch.sv
// Protection, fault reporting, drive-strength decode and thermal PWM of the power switch
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pst_consts.svh"

module pst_power_switch #(
    parameter int PWM_PERIOD = `PST_CLK_HZ / `PST_PWM_HZ,
    parameter int SCP_CLR_CYC = `PST_SCP_CLR_US * (`PST_CLK_HZ / 1000000),
    parameter int DS_FILT_CYC = `PST_DS_FILT_US * (`PST_CLK_HZ / 1000000)
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic [31:0]                 prdata,
    // Sensor and pin inputs
    input  wire pst_pkg::pst_pins_t     pins,
    // Power stage controls
    output logic                        switch_gate,
    output logic                        aux_reg_en,
    output logic                        neg_rail_en,
    output pst_pkg::pst_slew_set_t      slew_set,
    // Status outputs
    output logic                        alarm_n_out,
    output logic                        thermal_pwm_out
);

    localparam int IDM_BLANK_CYC =
        (`PST_IDM_BLANK_NS * (`PST_CLK_HZ / 1000000) + 999) / 1000;

    // Two-stage synchroniser for all pin inputs
    pst_pkg::pst_pins_t sync1_r;
    pst_pkg::pst_pins_t pin_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            pin_r   <= '0;
        end else begin
            sync1_r <= pins;
            pin_r   <= sync1_r;
        end
    end

    // Edge memory of synchronised levels
    logic cmd_d_r;
    logic supply_d_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_d_r    <= 1'b0;
            supply_d_r <= 1'b0;
        end else begin
            cmd_d_r    <= pin_r.switch_command;
            supply_d_r <= pin_r.supply_ok;
        end
    end
    logic cmd_rise;
    logic cmd_fall;
    logic supply_rise;
    assign cmd_rise    = pin_r.switch_command & ~cmd_d_r;
    assign cmd_fall    = ~pin_r.switch_command & cmd_d_r;
    assign supply_rise = pin_r.supply_ok & ~supply_d_r;

    // APB write strobe and fault latch reset request
    logic apb_wr;
    logic fault_rst;
    logic map_hit;
    assign apb_wr  = psel & penable & pwrite;
    assign map_hit = (paddr == `PST_OFS_STATUS) | (paddr == `PST_OFS_SLEW)
                   | (paddr == `PST_OFS_CTRL) | (paddr == `PST_OFS_DUTY);
    assign fault_rst = apb_wr & (paddr == `PST_OFS_CTRL) & pwdata[`PST_CTRL_RST_BIT];

    // Fault latches: short circuit, overcurrent, start-up
    logic        scp_lat_r;
    logic        scp_lat_nxt;
    logic        ocp_flag_r;
    logic        ocp_flag_nxt;
    logic        ocp_off_r;
    logic        ocp_off_nxt;
    logic        started_r;
    logic        started_nxt;
    logic [31:0] low_cnt_r;
    logic [31:0] low_cnt_nxt;
    always_comb begin
        low_cnt_nxt = pin_r.switch_command ? 32'h0 : low_cnt_r;
        if (!pin_r.switch_command && low_cnt_r < SCP_CLR_CYC[31:0]) begin
            low_cnt_nxt = low_cnt_r + 32'h1;
        end
        scp_lat_nxt = scp_lat_r;
        if (!pin_r.supply_ok || fault_rst
                || (low_cnt_r >= SCP_CLR_CYC[31:0])) begin
            scp_lat_nxt = 1'b0;
        end
        if (pin_r.scp_trip && pin_r.supply_ok) begin
            scp_lat_nxt = 1'b1;
        end
        ocp_flag_nxt = ocp_flag_r;
        if (cmd_rise || fault_rst || !pin_r.supply_ok) begin
            ocp_flag_nxt = 1'b0;
        end
        if (pin_r.ocp_trip) begin
            ocp_flag_nxt = 1'b1;
        end
        ocp_off_nxt = pin_r.switch_command ? (ocp_off_r | pin_r.ocp_trip) : 1'b0;
        started_nxt = pin_r.supply_ok & (started_r | pin_r.series_on);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scp_lat_r  <= 1'b0;
            ocp_flag_r <= 1'b0;
            ocp_off_r  <= 1'b0;
            started_r  <= 1'b0;
            low_cnt_r  <= 32'h0;
        end else begin
            scp_lat_r  <= scp_lat_nxt;
            ocp_flag_r <= ocp_flag_nxt;
            ocp_off_r  <= ocp_off_nxt;
            started_r  <= started_nxt;
            low_cnt_r  <= low_cnt_nxt;
        end
    end

    // Operating mode and ideal-rectify state machine
    pst_pkg::pst_mode_t mode_r;
    pst_pkg::pst_mode_t mode_nxt;
    pst_pkg::pst_idm_t  idm_r;
    pst_pkg::pst_idm_t  idm_nxt;
    logic [15:0]        blank_r;
    logic [15:0]        blank_nxt;
    always_comb begin
        mode_nxt  = mode_r;
        idm_nxt   = idm_r;
        blank_nxt = (blank_r != 16'h0) ? blank_r - 16'h1 : 16'h0;
        if (!pin_r.supply_ok) begin
            mode_nxt = pst_pkg::MODE_LOCKOUT;
        end else if (pin_r.drv_hot) begin
            mode_nxt = pst_pkg::MODE_DRV_SD;
        end else if (pin_r.die_hot) begin
            mode_nxt = pst_pkg::MODE_IDM;
        end else begin
            mode_nxt = pst_pkg::MODE_NORMAL;
        end
        if (mode_r != pst_pkg::MODE_IDM) begin
            idm_nxt = pst_pkg::IDM_WATCH;
        end else if (cmd_fall) begin
            idm_nxt   = pst_pkg::IDM_BLANK;
            blank_nxt = IDM_BLANK_CYC[15:0];
        end else begin
            case (idm_r)
                pst_pkg::IDM_BLANK: begin
                    if (blank_r <= 16'h1) begin
                        idm_nxt = pst_pkg::IDM_WATCH;
                    end
                end
                pst_pkg::IDM_WATCH: begin
                    if (pin_r.q3_current) begin
                        idm_nxt = pst_pkg::IDM_ON;
                    end
                end
                pst_pkg::IDM_ON: begin
                    if (pin_r.q1_current) begin
                        idm_nxt = pst_pkg::IDM_WATCH;
                    end
                end
                default: idm_nxt = pst_pkg::IDM_WATCH;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r  <= pst_pkg::MODE_LOCKOUT;
            idm_r   <= pst_pkg::IDM_WATCH;
            blank_r <= 16'h0;
        end else begin
            mode_r  <= mode_nxt;
            idm_r   <= idm_nxt;
            blank_r <= blank_nxt;
        end
    end

    // Drive-strength decode, one-time rail check and filtering
    pst_pkg::pst_slew_set_t raw_set;
    pst_pkg::pst_slew_set_t cand_r;
    pst_pkg::pst_slew_set_t cand_nxt;
    pst_pkg::pst_slew_set_t slew_r;
    pst_pkg::pst_slew_set_t slew_nxt;
    logic                   checked_r;
    logic                   checked_nxt;
    logic                   rail_lock_r;
    logic                   rail_lock_nxt;
    logic [31:0]            filt_r;
    logic [31:0]            filt_nxt;
    always_comb begin
        raw_set.res_code = pin_r.ds_res_code;
        if (pin_r.ds_open) begin
            raw_set.sel = pst_pkg::SLEW_OPEN;
        end else if (pin_r.ds_gnd) begin
            raw_set.sel = pst_pkg::SLEW_GND;
        end else if (pin_r.ds_rail) begin
            raw_set.sel = pst_pkg::SLEW_RAIL;
        end else begin
            raw_set.sel = pst_pkg::SLEW_RESIST;
        end
        checked_nxt   = checked_r | supply_rise;
        rail_lock_nxt = rail_lock_r | (supply_rise & ~checked_r & pin_r.ds_rail);
        cand_nxt      = raw_set;
        slew_nxt      = slew_r;
        filt_nxt      = 32'h0;
        if (rail_lock_r) begin
            slew_nxt.sel      = pst_pkg::SLEW_RAIL;
            slew_nxt.res_code = 4'h0;
        end else if (raw_set == cand_r) begin
            filt_nxt = filt_r;
            if (filt_r < DS_FILT_CYC[31:0]) begin
                filt_nxt = filt_r + 32'h1;
            end else begin
                slew_nxt = cand_r;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cand_r      <= '0;
            slew_r      <= '0;
            checked_r   <= 1'b0;
            rail_lock_r <= 1'b0;
            filt_r      <= 32'h0;
        end else begin
            cand_r      <= cand_nxt;
            slew_r      <= slew_nxt;
            checked_r   <= checked_nxt;
            rail_lock_r <= rail_lock_nxt;
            filt_r      <= filt_nxt;
        end
    end

    // Power stage enables, gate and alarm
    logic aux_r;
    logic aux_nxt;
    logic gate_r;
    logic gate_nxt;
    logic alarm_n_r;
    logic alarm_n_nxt;
    logic thermal_fault;
    assign thermal_fault = pin_r.die_hot | pin_r.drv_hot;
    always_comb begin
        aux_nxt = aux_r;
        if (!pin_r.supply_ok || pin_r.drv_hot) begin
            aux_nxt = 1'b0;
        end else if (supply_rise || mode_r == pst_pkg::MODE_DRV_SD) begin
            aux_nxt = 1'b1;
        end
        case (mode_r)
            pst_pkg::MODE_NORMAL:
                gate_nxt = pin_r.switch_command & ~ocp_off_r & ~scp_lat_r & started_r;
            pst_pkg::MODE_IDM:
                gate_nxt = (idm_r == pst_pkg::IDM_ON);
            default:
                gate_nxt = 1'b0;
        endcase
        // Independent of whether anyone watches the alarm pin
        alarm_n_nxt = ~(~pin_r.supply_ok | ~started_r | thermal_fault
                      | pin_r.ds_open | scp_lat_r | ocp_flag_r);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_r     <= 1'b0;
            gate_r    <= 1'b0;
            alarm_n_r <= 1'b0;
        end else begin
            aux_r     <= aux_nxt;
            gate_r    <= gate_nxt;
            alarm_n_r <= alarm_n_nxt;
        end
    end

    // Thermal PWM: duty from temperature, refreshed once per period
    logic [31:0] pwm_cnt_r;
    logic [31:0] pwm_cnt_nxt;
    logic [31:0] duty_r;
    logic [31:0] duty_nxt;
    logic        pwm_r;
    logic        pwm_nxt;
    logic [31:0] numer;
    logic [31:0] calc;
    logic [31:0] duty_min;
    always_comb begin
        duty_min = PWM_PERIOD / `PST_DUTY_MIN_DIV;
        numer    = 32'(pin_r.temp_code) * `PST_TMAP_SCALE;
        calc     = duty_min;
        if (pin_r.temp_code >= `PST_TEMP_FLOOR) begin
            calc = 32'((64'(numer - `PST_TMAP_OFS_X10) * 64'(PWM_PERIOD))
                   / `PST_TMAP_SLOPE_X10);
        end
        if (calc < duty_min) begin
            calc = duty_min;
        end
        duty_nxt    = duty_r;
        pwm_cnt_nxt = pwm_cnt_r + 32'h1;
        if (pwm_cnt_r >= PWM_PERIOD - 1) begin
            pwm_cnt_nxt = 32'h0;
            duty_nxt    = calc;
        end
        pwm_nxt = thermal_fault | (pwm_cnt_nxt < duty_nxt);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_r <= 32'h0;
            duty_r    <= 32'h0;
            pwm_r     <= 1'b0;
        end else begin
            pwm_cnt_r <= pwm_cnt_nxt;
            duty_r    <= duty_nxt;
            pwm_r     <= pwm_nxt;
        end
    end

    // APB read data, captured in the setup phase
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = rdata_r;
        if (psel && !penable) begin
            case (paddr)
                `PST_OFS_STATUS: rdata_nxt = {22'h0, scp_lat_r, ocp_flag_r, started_r,
                                    pin_r.supply_ok, pin_r.drv_hot, pin_r.die_hot,
                                    idm_r, mode_r};
                `PST_OFS_SLEW:   rdata_nxt = {25'h0, rail_lock_r, slew_r};
                `PST_OFS_CTRL:   rdata_nxt = `PST_CTRL_RESET;
                `PST_OFS_DUTY:   rdata_nxt = duty_r;
                default:         rdata_nxt = 32'h0;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Output drive
    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~map_hit;
    assign prdata          = rdata_r;
    assign switch_gate     = gate_r;
    assign aux_reg_en      = aux_r;
    assign neg_rail_en     = aux_r;
    assign slew_set        = slew_r;
    assign alarm_n_out     = alarm_n_r;
    assign thermal_pwm_out = pwm_r;

endmodule

// file: verilog/pst_consts.svh
// Constants for the power switch fault and temperature report block
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH

// APB register byte offsets
`define PST_OFS_STATUS     8'h00
`define PST_OFS_SLEW       8'h04
`define PST_OFS_CTRL       8'h08
`define PST_OFS_DUTY       8'h0C

// Control register fields
`define PST_CTRL_RST_BIT   0
`define PST_CTRL_RESET     32'h0000_0000

// Clock and timing
`define PST_CLK_HZ         100000000
`define PST_PWM_HZ         9000
`define PST_IDM_BLANK_NS   100
`define PST_SCP_CLR_US     50
`define PST_DS_FILT_US     100

// Temperature to duty mapping: temp = 162.3 * duty + 20.1
`define PST_TMAP_SLOPE_X10 1623
`define PST_TMAP_OFS_X10   201
`define PST_TMAP_SCALE     10
`define PST_DUTY_MIN_DIV   100
`define PST_TEMP_FLOOR     8'h19

`endif

// file: verilog/pst_pkg.sv
// Types for the power switch fault and temperature report block
package pst_pkg;

    // Top-level operating mode
    typedef enum logic [1:0] {
        MODE_LOCKOUT = 2'b00,
        MODE_NORMAL  = 2'b01,
        MODE_IDM     = 2'b10,
        MODE_DRV_SD  = 2'b11
    } pst_mode_t;

    // Ideal-rectify sub-state while the switch die is hot
    typedef enum logic [1:0] {
        IDM_BLANK = 2'b00,
        IDM_WATCH = 2'b01,
        IDM_ON    = 2'b10
    } pst_idm_t;

    // Decoded drive-strength setting
    typedef enum logic [1:0] {
        SLEW_OPEN   = 2'b00,
        SLEW_GND    = 2'b01,
        SLEW_RAIL   = 2'b10,
        SLEW_RESIST = 2'b11
    } pst_slew_t;

    // Pin-side inputs, all asynchronous to pclk
    typedef struct packed {
        logic       supply_ok;
        logic       series_on;
        logic       switch_command;
        logic       die_hot;
        logic       drv_hot;
        logic       ocp_trip;
        logic       scp_trip;
        logic       q1_current;
        logic       q3_current;
        logic       ds_open;
        logic       ds_gnd;
        logic       ds_rail;
        logic [3:0] ds_res_code;
        logic [7:0] temp_code;
    } pst_pins_t;

    // Slew setting as driven to the gate driver
    typedef struct packed {
        pst_slew_t  sel;
        logic [3:0] res_code;
    } pst_slew_set_t;

endpackage

// file: tb/pst_power_switch_sva.sv
// Assertion checker for the power switch fault and temperature report block
`timescale 1ns/1ps

module pst_power_switch_sva (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // APB
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [31:0]            prdata,
    // Pins and power stage
    input wire pst_pkg::pst_pins_t     pins,
    input wire logic                   switch_gate,
    input wire logic                   aux_reg_en,
    input wire logic                   neg_rail_en,
    input wire pst_pkg::pst_slew_set_t slew_set,
    // Status
    input wire logic                   alarm_n_out,
    input wire logic                   thermal_pwm_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    pst_pkg::pst_pins_t h1, h2, h3, h4;

    // Pin history; a level seen at both h3 and h4 tolerates a 3 or 4 edge latency
    always_ff @(posedge pclk) begin
        h1 <= pins;
        h2 <= h1;
        h3 <= h2;
        h4 <= h3;
    end

    a_lockout_off: assert property (!h3.supply_ok && !h4.supply_ok |->
        !alarm_n_out && !switch_gate && !aux_reg_en) else $error("lockout not honoured");
    a_thermal_alarm: assert property ((h3.die_hot && h4.die_hot) ||
        (h3.drv_hot && h4.drv_hot) |-> !alarm_n_out) else $error("alarm high while hot");
    a_hot_pwm_high: assert property ((h3.die_hot && h4.die_hot) ||
        (h3.drv_hot && h4.drv_hot) |-> thermal_pwm_out) else $error("temp output not high");
    a_drv_sd_off: assert property (h3.drv_hot && h4.drv_hot |->
        !aux_reg_en && !neg_rail_en && !switch_gate) else $error("driver shutdown missed");
    a_open_alarm: assert property (h3.ds_open && h4.ds_open |-> !alarm_n_out)
        else $error("alarm high with pin open");
    a_q1_gate_off: assert property (h3.die_hot && h4.die_hot && h3.q1_current &&
        h4.q1_current && !h3.q3_current && !h4.q3_current |-> !switch_gate)
        else $error("gate on with first quadrant current");
    a_ocp_alarm: assert property (h3.ocp_trip && h4.ocp_trip |->
        !alarm_n_out && !switch_gate) else $error("overcurrent not flagged");
    a_alarm_release: assert property ($rose(alarm_n_out) |-> h3.supply_ok &&
        h3.series_on && !h3.die_hot && !h3.drv_hot && !h3.ds_open && !h3.scp_trip)
        else $error("alarm released with a source active");
    a_rail_pair: assert property (aux_reg_en == neg_rail_en)
        else $error("regulator enables differ");
    a_rail_on_supply: assert property ($rose(aux_reg_en) |-> h3.supply_ok && !h3.drv_hot)
        else $error("regulator enabled without supply");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase not answered");
    a_bad_addr: assert property (psel && penable |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})) else $error("wrong slave error");

    // Main scenarios reached
    c_release: cover property ($rose(alarm_n_out));
    c_rectify_on: cover property (switch_gate && h3.die_hot);
    c_drv_off: cover property ($fell(aux_reg_en));
endmodule

bind pst_power_switch pst_power_switch_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .pins, .switch_gate, .aux_reg_en,
    .neg_rail_en, .slew_set, .alarm_n_out, .thermal_pwm_out);

// file: tb/pst_ctrl_model.sv
// Converter controller model driving the device pins
`timescale 1ns/1ps

module pst_ctrl_model (
    // Clock
    input  wire logic               pclk,
    // Levels asked for by the test sequence
    input  wire pst_pkg::pst_pins_t req,
    // Levels at the device pins
    output pst_pkg::pst_pins_t      pins
);
    logic [1:0]         step_r = 2'h0;
    pst_pkg::pst_pins_t pins_nxt;

    // Pass the asked levels; the resistor code moves one step per four cycles
    always_comb begin
        pins_nxt = req;
        pins_nxt.ds_res_code = pins.ds_res_code;
        if (step_r == 2'h0 && pins.ds_res_code < req.ds_res_code) begin
            pins_nxt.ds_res_code = pins.ds_res_code + 4'h1;
        end else if (step_r == 2'h0 && pins.ds_res_code > req.ds_res_code) begin
            pins_nxt.ds_res_code = pins.ds_res_code - 4'h1;
        end
    end

    // Register the pin levels
    initial pins = '0;
    always @(posedge pclk) begin
        step_r <= step_r + 2'h1;
        pins   <= pins_nxt;
    end
endmodule

// file: tb/pst_power_switch_tb.sv
// Self-checking testbench for the power switch fault and temperature report block
`timescale 1ns/1ps
`include "pst_consts.svh"

module pst_power_switch_tb;
    localparam int P   = 200;
    localparam int LAT = 6;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0000_0000;
    logic                   pready, pslverr, switch_gate, aux_reg_en, neg_rail_en;
    logic                   alarm_n_out, thermal_pwm_out, er;
    logic [31:0]            prdata, rd;
    pst_pkg::pst_pins_t     req = '0;
    pst_pkg::pst_pins_t     pins, r, t;
    pst_pkg::pst_slew_set_t slew_set;
    logic [7:0]             tc [5] = '{8'h0A, 8'h55, 8'hA0, 8'h19, 8'h96};
    logic [7:0]             dc [5] = '{8'h02, 8'h4F, 8'hAC, 8'h06, 8'hA0};
    int                     err_total = 0;
    int                     n_checks = 0;
    int                     hi;

    pst_ctrl_model i_ctrl (.pclk, .req, .pins);
    pst_power_switch #(.PWM_PERIOD(P), .SCP_CLR_CYC(20), .DS_FILT_CYC(8)) i_dut (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .pins, .switch_gate, .aux_reg_en, .neg_rail_en, .slew_set, .alarm_n_out,
        .thermal_pwm_out);

    // Clock at 100 MHz
    initial forever #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic drv(input pst_pkg::pst_pins_t v);
        @(posedge pclk);
        req <= v;
    endtask
    // Two-cycle fault pulse, then settle
    task automatic pls(input pst_pkg::pst_pins_t v);
        drv(v);
        drv(v);
        drv(r);
        wt(LAT);
    endtask
    // One APB transfer; waits for pready, the watchdog bounds the wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask
    task automatic stop_test;
        $display("Checks made: %0d, mismatches: %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        stop_test;
    end

    // Main sequence
    initial begin
        r = '0;
        r.ds_res_code = 4'h5;
        req = r;
        wt(3);
        chk(32'(alarm_n_out), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        wt(8);
        chk(32'(alarm_n_out), 32'h0);
        r.supply_ok = 1'b1;
        drv(r);
        wt(8);
        chk(32'(alarm_n_out), 32'h0);
        chk(32'(aux_reg_en), 32'h1);
        r.series_on = 1'b1;
        drv(r);
        wt(60);
        chk(32'(alarm_n_out), 32'h1);
        rdc(`PST_OFS_STATUS, 32'h3, 32'h1);
        rdc(`PST_OFS_SLEW, 32'h7F, 32'h35);
        chk({26'h0, slew_set}, 32'h35);
        r.switch_command = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'(switch_gate), 32'h1);
        // Overcurrent, held through the command fall, released by the next command rise
        t = r;
        t.ocp_trip = 1'b1;
        pls(t);
        chk(32'(alarm_n_out), 32'h0);
        chk(32'(switch_gate), 32'h0);
        r.switch_command = 1'b0;
        drv(r);
        wt(LAT);
        chk(32'(alarm_n_out), 32'h0);
        r.switch_command = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'(alarm_n_out), 32'h1);
        // Short circuit latch, cleared by a long low command, then by software
        t = r;
        t.scp_trip = 1'b1;
        pls(t);
        chk(32'(switch_gate), 32'h0);
        wt(40);
        chk(32'(alarm_n_out), 32'h0);
        rdc(`PST_OFS_STATUS, 32'h200, 32'h200);
        r.switch_command = 1'b0;
        drv(r);
        wt(30);
        r.switch_command = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'(alarm_n_out), 32'h1);
        chk(32'(switch_gate), 32'h1);
        pls(t);
        chk(32'(alarm_n_out), 32'h0);
        apb(1'b1, `PST_OFS_CTRL, 32'h0000_0001);
        wt(LAT);
        chk(32'(alarm_n_out), 32'h1);
        rdc(`PST_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
        // Thermal states and ideal rectification
        r.die_hot = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'(alarm_n_out), 32'h0);
        chk(32'(thermal_pwm_out), 32'h1);
        rdc(`PST_OFS_STATUS, 32'h3, 32'h2);
        r.q3_current = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'(switch_gate), 32'h1);
        // A command fall blanks the rectifier before it may turn on again
        r.switch_command = 1'b0;
        drv(r);
        wt(LAT);
        chk(32'(switch_gate), 32'h0);
        rdc(`PST_OFS_STATUS, 32'hF, 32'h2);
        wt(20);
        chk(32'(switch_gate), 32'h1);
        r.switch_command = 1'b1;
        r.q3_current = 1'b0;
        r.q1_current = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'(switch_gate), 32'h0);
        r.q1_current = 1'b0;
        r.q3_current = 1'b1;
        r.drv_hot = 1'b1;
        drv(r);
        wt(LAT);
        chk(32'({switch_gate, aux_reg_en, neg_rail_en}), 32'h0);
        rdc(`PST_OFS_STATUS, 32'h3, 32'h3);
        r.drv_hot = 1'b0;
        drv(r);
        wt(LAT);
        chk(32'({switch_gate, aux_reg_en}), 32'h3);
        rdc(`PST_OFS_STATUS, 32'h3, 32'h2);
        r.die_hot = 1'b0;
        r.q3_current = 1'b0;
        drv(r);
        wt(LAT);
        chk(32'(alarm_n_out), 32'h1);
        rdc(`PST_OFS_STATUS, 32'h3, 32'h1);
        // Drive-strength pin open and grounded
        r.ds_open = 1'b1;
        drv(r);
        wt(30);
        chk(32'(alarm_n_out), 32'h0);
        rdc(`PST_OFS_SLEW, 32'h30, 32'h00);
        r.ds_open = 1'b0;
        r.ds_gnd = 1'b1;
        drv(r);
        wt(30);
        chk(32'(alarm_n_out), 32'h1);
        rdc(`PST_OFS_SLEW, 32'h30, 32'h10);
        chk({26'h0, slew_set}, 32'h15);
        r.ds_gnd = 1'b0;
        drv(r);
        // Temperature duty table and measured high time over one period
        for (int i = 0; i < 5; i++) begin
            r.temp_code = tc[i];
            drv(r);
            wt(2 * P + 10);
            rdc(`PST_OFS_DUTY, 32'hFFFF_FFFF, {24'h0, dc[i]});
            hi = 0;
            repeat (P) begin
                @(posedge pclk);
                hi += (thermal_pwm_out === 1'b1);
            end
            chk(32'(hi), {24'h0, dc[i]});
        end
        // Unmapped and read-only places
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `PST_OFS_STATUS, 32'hFFFF_FFFF);
        chk(32'(er), 32'h0);
        rdc(`PST_OFS_STATUS, 32'h3, 32'h1);
        // Lockout, then a second reset with the pin tied to the rail
        r.supply_ok = 1'b0;
        drv(r);
        wt(LAT);
        chk(32'({alarm_n_out, switch_gate, aux_reg_en}), 32'h0);
        r.ds_rail = 1'b1;
        drv(r);
        presetn <= 1'b0;
        wt(4);
        chk(32'(alarm_n_out), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        // The one-time check at the first supply rise locks the setting
        r.supply_ok = 1'b1;
        drv(r);
        wt(30);
        chk(32'(aux_reg_en), 32'h1);
        rdc(`PST_OFS_SLEW, 32'h70, 32'h60);
        chk({26'h0, slew_set}, 32'h20);
        r.ds_rail = 1'b0;
        r.ds_gnd = 1'b1;
        drv(r);
        wt(30);
        rdc(`PST_OFS_SLEW, 32'h70, 32'h60);
        chk({26'h0, slew_set}, 32'h20);
        stop_test;
    end
endmodule
